// ### rtl/eeh_pkg.sv
package eeh_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 64;
   localparam int CLK_MHZ = 10;
   // Low strobe width, ns
   localparam int WP_NS = 100;
   localparam int WP_CYC = (WP_NS * CLK_MHZ + 999) / 1000;
   // Setup before strobe low / hold after, ns
   localparam int SU_NS = 50;
   localparam int SU_CYC = (SU_NS * CLK_MHZ + 999) / 1000;
   // Byte load window, us, longest
   localparam int BLC_US = 150;
   localparam int BLC_CYC = BLC_US * CLK_MHZ;
   // Program cycle time, ms
   localparam int WC_MS = 10;
   localparam int WC_CYC = WC_MS * 1000 * CLK_MHZ;
   // Power-on write block, ms
   localparam int PON_MS = 5;
   localparam int PON_CYC = PON_MS * 1000 * CLK_MHZ;
   localparam logic [5:0] CMD_IDLE = 6'h00;
   typedef enum logic [1:0] {
      EEH_OP_READ = 2'b00,
      EEH_OP_WRITE = 2'b01,
      EEH_OP_LOCK = 2'b10,
      EEH_OP_UNLOCK = 2'b11
   } eeh_op_t;
endpackage

// ### rtl/eeh_strobe.sv
`timescale 1ns/1ps
module eeh_strobe #(
   parameter int CNT_W = 4
) (
   input wire logic i_core_clk, // Clock
   input wire logic i_rst, // Async reset
   input wire logic i_load, // Start count
   input wire logic [CNT_W-1:0] i_count, // Cycles to wait
   output logic o_busy // Counting
);
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   always_comb begin
      cnt_next = cnt_reg;
      if (i_load) begin
         cnt_next = i_count;
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   assign o_busy = (cnt_reg != '0);
endmodule

// ### rtl/eeh_ctrl.sv
`timescale 1ns/1ps
module eeh_ctrl #(
   parameter int MAX_BYTES = 64,
   parameter int BLC_CYC = eeh_pkg::BLC_CYC,
   parameter int WC_CYC = eeh_pkg::WC_CYC,
   parameter int PON_CYC = eeh_pkg::PON_CYC,
   parameter logic [12:0] CA0 = 13'h0AAA, // command addresses
   parameter logic [12:0] CA1 = 13'h0555,
   parameter logic [12:0] CA2 = 13'h0AAA,
   parameter logic [7:0] CD0 = 8'hAA, // command data
   parameter logic [7:0] CD1 = 8'h55,
   parameter logic [7:0] CD_LOCK = 8'hA0,
   parameter logic [7:0] CD_UNLOCK = 8'h20
) (
   input wire logic i_core_clk, // Clock
   input wire logic i_rst, // Async reset
   input wire logic i_power_ok, // Supply valid
   input wire logic i_req, // Request pulse
   input wire eeh_pkg::eeh_op_t i_op, // Operation
   input wire logic i_prefix, // Precede write with command triple
   input wire logic [12:0] i_addr, // Start address
   input wire logic [7:0] i_wdata, // Byte to write
   input wire logic i_wlast, // Last byte of page
   output logic o_wnext, // Byte taken pulse
   output logic o_busy, // Busy
   output logic o_done, // Done pulse
   output logic o_timeout, // Poll timed out or write refused, level till next req
   output logic [7:0] o_rdata, // Read byte
   output logic [12:0] o_mem_addr, // Address lines
   output logic o_ce_n, // Chip enable
   output logic o_oe_n, // Output enable
   output logic o_we_n, // Write strobe
   output logic [7:0] o_dq_o, // Data out
   output logic o_dq_oe_n, // Data enable, low drives
   input wire logic [7:0] i_dq_i // Data in
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_SET = 3'b001, S_LOW = 3'b010,
      S_HIGH = 3'b011, S_RD = 3'b100, S_POLL = 3'b101,
      S_WAIT = 3'b110
   } eeh_st_t;
   localparam int TW = $clog2(WC_CYC + BLC_CYC + 2);
   eeh_st_t st_reg, st_next;
   logic [TW-1:0] tmr_reg, tmr_next;
   logic [2:0] cmd_reg, cmd_next;
   logic [6:0] nby_reg, nby_next;
   logic [12:0] a_reg, a_next, la_reg, la_next;
   logic [7:0] d_reg, d_next, ld_reg, ld_next, rd_reg, rd_next;
   logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
   logic dqe_reg, dqe_next, busy_reg, busy_next, done_reg, done_next;
   logic to_reg, to_next, wn_reg, wn_next, wr_reg, wr_next;
   logic ph_reg, ph_next, lst_reg, lst_next;
   logic [$clog2(PON_CYC+1)-1:0] pon_reg, pon_next;
   logic ph_busy, ph_load;
   logic [3:0] ph_cnt;
   logic [6:0] page_reg, page_next;
   eeh_strobe #(.CNT_W(4)) u_ph (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_load(ph_load),
      .i_count(ph_cnt),
      .o_busy(ph_busy)
   );
   initial begin
      if (WC_CYC > eeh_pkg::WC_CYC) begin
         $error("program time above maximum");
      end
   end
   always_comb begin
      pon_next = pon_reg;
      if (!i_power_ok) begin
         pon_next = PON_CYC[$bits(pon_reg)-1:0];
      end else if (pon_reg != '0) begin
         pon_next = pon_reg - 1'b1;
      end
   end
   // Command slot: 0..2 are prefix bytes, 3 is payload
   function automatic logic [12:0] slot_a(input logic [2:0] s,
                                          input logic [12:0] ua);
      slot_a = (s == 3'h0) ? CA0 : (s == 3'h1) ? CA1 :
               (s == 3'h2) ? CA2 : ua;
   endfunction
   always_comb begin
      st_next = st_reg; tmr_next = tmr_reg; cmd_next = cmd_reg;
      nby_next = nby_reg; a_next = a_reg; d_next = d_reg;
      la_next = la_reg; ld_next = ld_reg; rd_next = rd_reg;
      ce_next = ce_reg; oe_next = oe_reg; we_next = we_reg;
      dqe_next = dqe_reg; busy_next = busy_reg; done_next = 1'b0;
      to_next = to_reg; wn_next = 1'b0; wr_next = wr_reg;
      ph_next = ph_reg; page_next = page_reg;
      lst_next = lst_reg;
      ph_load = 1'b0; ph_cnt = 4'h0;
      unique case (st_reg)
         S_IDLE: begin
            ce_next = 1'b1; oe_next = 1'b1; we_next = 1'b1;
            dqe_next = 1'b1; busy_next = 1'b0;
            if (i_req && (i_op == eeh_pkg::EEH_OP_READ)) begin
               busy_next = 1'b1; to_next = 1'b0;
               a_next = i_addr; ce_next = 1'b0; oe_next = 1'b0;
               ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::WP_CYC);
               st_next = S_RD;
            end else if (i_req && pon_reg == '0 && i_power_ok) begin
               busy_next = 1'b1; to_next = 1'b0; wr_next = 1'b1;
               nby_next = '0; page_next = i_addr[12:6];
               cmd_next = (i_op == eeh_pkg::EEH_OP_WRITE && !i_prefix) ?
                          3'h3 : 3'h0;
               st_next = S_SET;
            end else if (i_req) begin
               done_next = 1'b1; to_next = 1'b1;
            end
         end
         S_SET: begin
            // Address and data set before the strobe falls
            a_next = slot_a(cmd_reg, {page_reg, i_addr[5:0]});
            d_next = (cmd_reg == 3'h0) ? CD0 : (cmd_reg == 3'h1) ? CD1 :
                     (cmd_reg == 3'h2) ?
                     ((i_op == eeh_pkg::EEH_OP_UNLOCK) ? CD_UNLOCK :
                      CD_LOCK) : i_wdata;
            oe_next = 1'b1; ce_next = 1'b0; dqe_next = 1'b0;
            // Last flag belongs to this byte, not the one shown after
            lst_next = i_wlast;
            ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::SU_CYC);
            st_next = S_LOW;
         end
         S_LOW: begin
            if (!ph_busy && we_reg) begin
               we_next = 1'b0;
               ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::WP_CYC);
            end else if (!ph_busy) begin
               we_next = 1'b1;
               ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::SU_CYC);
               if (cmd_reg == 3'h3) begin
                  wn_next = 1'b1; nby_next = nby_reg + 1'b1;
                  la_next = a_reg; ld_next = d_reg;
               end
               st_next = S_HIGH;
            end
         end
         S_HIGH: begin
            if (!ph_busy) begin
               dqe_next = 1'b1; ce_next = 1'b1;
               if (cmd_reg < 3'h2 ||
                   (cmd_reg == 3'h2 &&
                    i_op == eeh_pkg::EEH_OP_WRITE)) begin
                  cmd_next = cmd_reg + 1'b1; st_next = S_SET;
               end else if (cmd_reg == 3'h3 && !lst_reg &&
                            nby_reg < 7'(MAX_BYTES)) begin
                  st_next = S_SET;
               end else begin
                  // Lapse of load window starts programming
                  if (cmd_reg == 3'h2) begin
                     la_next = a_reg; ld_next = d_reg;
                  end
                  tmr_next = TW'(WC_CYC + BLC_CYC);
                  st_next = S_POLL;
               end
            end
         end
         S_POLL: begin
            // Poll last byte; true bit 7 with toggle stopped means done
            if (tmr_reg == '0) begin
               to_next = 1'b1; done_next = 1'b1; st_next = S_IDLE;
            end else begin
               tmr_next = tmr_reg - 1'b1;
               a_next = la_reg; ce_next = 1'b0; oe_next = 1'b0;
               ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::WP_CYC);
               st_next = S_RD;
            end
         end
         S_RD: begin
            if (!ph_busy) begin
               rd_next = i_dq_i; ce_next = 1'b1; oe_next = 1'b1;
               if (!wr_reg) begin
                  done_next = 1'b1; st_next = S_IDLE;
               end else begin
                  // Toggle stopped and true bit 7 seen
                  ph_next = i_dq_i[6];
                  if (i_dq_i[7] == ld_reg[7] &&
                      i_dq_i[6] == ph_reg) begin
                     wr_next = 1'b0; done_next = 1'b1;
                     st_next = S_IDLE;
                  end else begin
                     ph_load = 1'b1; ph_cnt = 4'(eeh_pkg::SU_CYC);
                     st_next = S_WAIT;
                  end
               end
               tmr_next = (tmr_reg > TW'(eeh_pkg::WP_CYC)) ?
                          tmr_reg - TW'(eeh_pkg::WP_CYC) : '0;
            end
         end
         S_WAIT: begin
            if (!ph_busy) begin
               st_next = S_POLL;
            end
         end
         default: st_next = S_IDLE;
      endcase
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= S_IDLE; tmr_reg <= '0; cmd_reg <= '0;
         nby_reg <= '0; a_reg <= '0; d_reg <= '0; la_reg <= '0;
         ld_reg <= '0; rd_reg <= '0; ce_reg <= 1'b1; oe_reg <= 1'b1;
         we_reg <= 1'b1; dqe_reg <= 1'b1; busy_reg <= 1'b0;
         done_reg <= 1'b0; to_reg <= 1'b0; wn_reg <= 1'b0;
         wr_reg <= 1'b0; ph_reg <= 1'b0; page_reg <= '0;
         lst_reg <= 1'b0;
         pon_reg <= PON_CYC[$bits(pon_reg)-1:0];
      end else begin
         st_reg <= st_next; tmr_reg <= tmr_next; cmd_reg <= cmd_next;
         nby_reg <= nby_next; a_reg <= a_next; d_reg <= d_next;
         la_reg <= la_next; ld_reg <= ld_next; rd_reg <= rd_next;
         ce_reg <= ce_next; oe_reg <= oe_next; we_reg <= we_next;
         dqe_reg <= dqe_next; busy_reg <= busy_next;
         done_reg <= done_next; to_reg <= to_next; wn_reg <= wn_next;
         wr_reg <= wr_next; ph_reg <= ph_next; page_reg <= page_next;
         lst_reg <= lst_next;
         pon_reg <= pon_next;
      end
   end
   assign o_mem_addr = a_reg;
   assign o_dq_o = d_reg;
   assign o_ce_n = ce_reg;
   assign o_oe_n = oe_reg;
   assign o_we_n = we_reg;
   assign o_dq_oe_n = dqe_reg;
   assign o_rdata = rd_reg;
   assign o_busy = busy_reg;
   assign o_done = done_reg;
   assign o_timeout = to_reg;
   assign o_wnext = wn_reg;
   property p_no_drive_in_read;
      @(posedge i_core_clk) disable iff (i_rst)
      !o_oe_n |-> o_dq_oe_n;
   endproperty
   a_no_drive_in_read: assert property (p_no_drive_in_read)
      else $error("data driven while output enabled");
   property p_we_needs_ce;
      @(posedge i_core_clk) disable iff (i_rst)
      !o_we_n |-> (!o_ce_n && o_oe_n);
   endproperty
   a_we_needs_ce: assert property (p_we_needs_ce)
      else $error("strobe low without chip low and oe high");
   property p_we_width;
      @(posedge i_core_clk) disable iff (i_rst)
      $fell(o_we_n) |-> !o_we_n [*1] ##1 !o_we_n;
   endproperty
   a_we_width: assert property (p_we_width)
      else $error("strobe pulse too short");
   property p_addr_stable;
      @(posedge i_core_clk) disable iff (i_rst)
      !o_we_n |=> $stable(o_mem_addr) && $stable(o_dq_o);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("address or data moved under strobe");
   property p_page_same;
      @(posedge i_core_clk) disable iff (i_rst)
      ($fell(o_we_n) && cmd_reg == 3'h3) |->
         o_mem_addr[12:6] == page_reg;
   endproperty
   a_page_same: assert property (p_page_same)
      else $error("page bits changed within page");
   property p_pon_block;
      @(posedge i_core_clk) disable iff (i_rst)
      (pon_reg != '0) |-> !(st_reg == S_IDLE && st_next == S_SET);
   endproperty
   a_pon_block: assert property (p_pon_block)
      else $error("write started during power-on delay");
   property p_read_oe;
      @(posedge i_core_clk) disable iff (i_rst)
      (st_reg == S_RD) |-> (!o_ce_n && !o_oe_n && o_we_n);
   endproperty
   a_read_oe: assert property (p_read_oe)
      else $error("read without proper controls");
   property p_load_window;
      @(posedge i_core_clk) disable iff (i_rst)
      o_wnext |-> ##[1:40] (st_reg == S_POLL || o_wnext);
   endproperty
   a_load_window: assert property (p_load_window)
      else $error("next page byte late");
endmodule

// ### tb/eeh_dev_model.sv
`timescale 1ns/1ps
module eeh_dev_model #(
   parameter int BLC = 20,
   parameter int PROG = 100,
   parameter int PON = 5,
   parameter logic [12:0] CA0 = 13'h0AAA,
   parameter logic [12:0] CA1 = 13'h0555,
   parameter logic [12:0] CA2 = 13'h0AAA,
   parameter logic [7:0] CD0 = 8'hAA,
   parameter logic [7:0] CD1 = 8'h55,
   parameter logic [7:0] CD_LOCK = 8'hA0,
   parameter logic [7:0] CD_UNLOCK = 8'hC0
) (
   input wire logic i_clk, // Model timer clock
   input wire logic i_power_ok, // Supply valid
   input wire logic [12:0] i_addr, // Address lines
   input wire logic i_ce_n, // Chip enable
   input wire logic i_oe_n, // Output enable
   input wire logic i_we_n, // Write strobe
   input wire logic [7:0] i_dq, // Data bus in
   output logic [7:0] o_dq, // Data bus out
   output logic o_dq_oe_n // Drives when low
);
   logic [7:0] mem [8192];
   logic [7:0] pbuf [64];
   logic [63:0] pmask;
   logic [12:0] alat;
   logic [6:0] page;
   logic [7:0] last_d;
   logic wr_p, rd_p, loading, locked, allow, tog, hit;
   int blc_cnt, prog_cnt, pon_cnt, cmd_st;
   wire rd = !i_ce_n && !i_oe_n && i_we_n;
   // Pins sampled per clock, so sub-cycle glitches never count
   wire wr = !i_ce_n && !i_we_n && i_oe_n;
   wire busy = loading || prog_cnt != 0;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {pmask, alat, page, last_d} = '0;
      {wr_p, rd_p, loading, allow, tog, hit} = '0;
      locked = 1'h0;
      blc_cnt = 0;
      prog_cnt = 0;
      pon_cnt = PON;
      cmd_st = 0;
   end
   assign o_dq_oe_n = !rd;
   assign o_dq = busy ? {~last_d[7], tog, mem[i_addr][5:0]} :
      mem[i_addr];
   always @(negedge i_clk) begin
      pon_cnt = !i_power_ok ? PON : (pon_cnt > 0 ? pon_cnt - 1 : 0);
      if (rd && !rd_p && busy) tog = ~tog;
      if (wr && !wr_p) alat = i_addr;
      if (!wr && wr_p && prog_cnt == 0 && i_power_ok && pon_cnt == 0) begin
         if (!loading) begin
            pmask = '0;
            cmd_st = 0;
            allow = !locked;
         end
         loading = 1'h1;
         blc_cnt = BLC;
         last_d = i_dq;
         case (cmd_st)
            0: hit = alat == CA0 && i_dq == CD0;
            1: hit = alat == CA1 && i_dq == CD1;
            2: hit = alat == CA2 && (i_dq == CD_LOCK || i_dq == CD_UNLOCK);
            default: hit = 1'h0;
         endcase
         if (hit) begin
            cmd_st++;
            if (cmd_st == 3) begin
               locked = i_dq == CD_LOCK;
               allow = 1'h1;
            end
         end else begin
            if (cmd_st != 4) page = alat[12:6];
            cmd_st = 4;
            pbuf[alat[5:0]] = i_dq;
            pmask[alat[5:0]] = 1'h1;
         end
      end else if (loading) begin
         blc_cnt--;
         if (blc_cnt == 0) begin
            for (int j = 0; j < 64; j++) begin
               if (allow && pmask[j]) mem[{page, 6'(j)}] = pbuf[j];
            end
            loading = 1'h0;
            prog_cnt = PROG;
         end
      end else if (prog_cnt > 0) begin
         prog_cnt--;
      end
      wr_p = wr;
      rd_p = rd;
   end
endmodule

// ### tb/eeh_ctrl_tb.sv
`timescale 1ns/1ps
module eeh_ctrl_tb;
   logic i_core_clk, i_rst, i_power_ok, i_req, i_prefix, i_wlast;
   eeh_pkg::eeh_op_t i_op;
   logic [12:0] i_addr, o_mem_addr;
   logic [7:0] i_wdata, o_rdata, o_dq_o, dev_dq, bus, prev_bus;
   logic o_wnext, o_busy, o_done, o_timeout, o_ce_n, o_oe_n, o_we_n;
   logic o_dq_oe_n, dev_oe_n;
   int bad_count, total_checks;
   logic [12:0] aq[$];
   logic [7:0] wq[$];
   // Released bus shows a changing pattern, never a stale value
   assign bus = !o_dq_oe_n ? o_dq_o : (!dev_oe_n ? dev_dq : ~prev_bus);
   always @(posedge i_core_clk) prev_bus <= bus;
   eeh_ctrl #(.BLC_CYC(20), .WC_CYC(200), .PON_CYC(10),
      .CD_UNLOCK(8'hC0)) eeh_ctrl_inst (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .i_power_ok(i_power_ok), .i_req(i_req), .i_op(i_op),
      .i_prefix(i_prefix), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wlast(i_wlast), .o_wnext(o_wnext), .o_busy(o_busy),
      .o_done(o_done), .o_timeout(o_timeout), .o_rdata(o_rdata),
      .o_mem_addr(o_mem_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
      .o_we_n(o_we_n), .o_dq_o(o_dq_o), .o_dq_oe_n(o_dq_oe_n),
      .i_dq_i(bus));
   eeh_dev_model eeh_dev_model_inst (.i_clk(i_core_clk),
      .i_power_ok(i_power_ok), .i_addr(o_mem_addr), .i_ce_n(o_ce_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(bus), .o_dq(dev_dq),
      .o_dq_oe_n(dev_oe_n));
   task automatic check8(string nm, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check1(string nm, logic e, logic g);
      check8(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic run_op(eeh_pkg::eeh_op_t op, logic pf);
      int k;
      int n;
      k = 0;
      n = 0;
      @(negedge i_core_clk);
      i_req = 1'h1;
      i_op = op;
      i_prefix = pf;
      i_addr = aq[0];
      i_wdata = wq[0];
      i_wlast = aq.size() == 1;
      @(negedge i_core_clk);
      i_req = 1'h0;
      if (op == eeh_pkg::EEH_OP_READ)
         check1("busy", 1'h1, o_busy);
      while (o_done !== 1'h1 && n < 4000) begin
         if (o_wnext === 1'h1 && k + 1 < aq.size()) begin
            k++;
            i_addr = aq[k];
            i_wdata = wq[k];
            i_wlast = k + 1 == aq.size();
         end
         @(negedge i_core_clk);
         n++;
      end
      check1("done", 1'h1, o_done);
   endtask
   task automatic rd(logic [12:0] a, logic [7:0] e);
      aq = {a};
      wq = {8'h00};
      run_op(eeh_pkg::EEH_OP_READ, 1'h0);
      check8("rdata", e, o_rdata);
   endtask
   task automatic wr(logic [12:0] a, logic [7:0] d, logic pf, logic eto);
      aq = {a};
      wq = {d};
      run_op(eeh_pkg::EEH_OP_WRITE, pf);
      check1("timeout", eto, o_timeout);
   endtask
   task automatic t_power_byte;
      wr(13'h0010, 8'h11, 1'h0, 1'h1);
      repeat (20) @(negedge i_core_clk);
      rd(13'h0010, 8'hFF);
      wr(13'h0123, 8'h3C, 1'h0, 1'h0);
      rd(13'h0123, 8'h3C);
      check1("ce_n idle", 1'h1, o_ce_n);
      @(negedge i_core_clk);
      check1("busy idle", 1'h0, o_busy);
   endtask
   task automatic t_page;
      aq = {13'h0045, 13'h0042, 13'h0045, 13'h007F};
      wq = {8'h01, 8'h02, 8'h03, 8'h04};
      run_op(eeh_pkg::EEH_OP_WRITE, 1'h0);
      check1("timeout", 1'h0, o_timeout);
      rd(13'h0045, 8'h03);
      rd(13'h0042, 8'h02);
      rd(13'h007F, 8'h04);
      rd(13'h0040, 8'hFF);
      aq = {};
      wq = {};
      for (int j = 63; j >= 0; j--) begin
         aq.push_back(13'h0080 + 13'(j));
         wq.push_back(8'(j) ^ 8'h5A);
      end
      run_op(eeh_pkg::EEH_OP_WRITE, 1'h0);
      rd(13'h00BF, 8'h65);
      rd(13'h0080, 8'h5A);
   endtask
   task automatic t_lock;
      aq = {13'h0000};
      wq = {8'h00};
      run_op(eeh_pkg::EEH_OP_LOCK, 1'h0);
      check1("timeout", 1'h0, o_timeout);
      wr(13'h0200, 8'hA5, 1'h0, 1'h0);
      rd(13'h0200, 8'hFF);
      wr(13'h0201, 8'h96, 1'h1, 1'h0);
      rd(13'h0201, 8'h96);
      rd(13'h0AAA, 8'hFF);
      i_power_ok = 1'h0;
      wr(13'h0203, 8'h11, 1'h0, 1'h1);
      i_power_ok = 1'h1;
      repeat (20) @(negedge i_core_clk);
      wr(13'h0203, 8'hA5, 1'h0, 1'h0);
      rd(13'h0203, 8'hFF);
      run_op(eeh_pkg::EEH_OP_UNLOCK, 1'h0);
      wr(13'h0202, 8'h77, 1'h0, 1'h0);
      rd(13'h0202, 8'h77);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      i_core_clk = 1'h0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   initial begin
      repeat (60000) @(posedge i_core_clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      {i_req, i_prefix, i_wlast, i_addr, i_wdata, prev_bus} = '0;
      i_op = eeh_pkg::EEH_OP_READ;
      i_power_ok = 1'h1;
      bad_count = 0;
      total_checks = 0;
      i_rst = 1'h1;
      repeat (10) @(negedge i_core_clk);
      i_rst = 1'h0;
      t_power_byte();
      t_page();
      t_lock();
      report_and_stop();
   end
endmodule
